// [design/bsc_pkg.sv]
package bsc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_BUS_NUM = 8'h18;
    localparam logic [7:0] OFS_IO_STS = 8'h1c;
    localparam logic [7:0] OFS_BRIDGE_CTL = 8'h3c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h40;
    localparam int SUB_BUS_LSB = 16;
    localparam int SEC_LAT_LSB = 24;
    localparam int IO_BASE_CAP_LSB = 0;
    localparam int IO_BASE_LSB = 4;
    localparam int IO_LIMIT_CAP_LSB = 8;
    localparam int IO_LIMIT_LSB = 12;
    localparam int CAP_66MHZ_BIT = 21;
    localparam int FAST_B2B_BIT = 23;
    localparam int MDPE_BIT = 24;
    localparam int DEVSEL_LSB = 25;
    localparam int STA_BIT = 27;
    localparam int RTA_BIT = 28;
    localparam int RMA_BIT = 29;
    localparam int RSE_BIT = 30;
    localparam int DPE_BIT = 31;
    localparam int PAR_EN_BIT = 16;
    localparam logic [1:0] IO_CAP_32BIT = 2'h1;
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam logic [7:0] SUB_BUS_RST = 8'h00;
    localparam logic [7:0] SEC_LAT_RST = 8'h00;
    localparam logic [3:0] IO_BASE_RST = 4'h0;
    localparam logic [3:0] IO_LIMIT_RST = 4'h0;
    localparam logic [31:0] STICKY_MASK = 32'hf900_0000;
    localparam logic [31:0] STICKY_RST = 32'h0000_0000;
    localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;
endpackage

// [design/bsc_regs.sv]
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - subordinate bus number, eight bits RW at 23:16, reset zero.
// RULE_02 - secondary latency timer, eight bits RW at 31:24, reset zero.
// RULE_03 - io base bits 1:0 and limit bits 9:8 always read 01.
// RULE_04 - io base field bits 7:4, RW, reset zero.
// RULE_05 - io limit field bits 15:12, RW, reset zero, window top 0FFFh.
// RULE_06 - status bit 21 reads one: 66MHz capable.
// RULE_07 - status bit 23 reads one while secondary bus in PCI mode.
// RULE_08 - bit 24 set on read data parity error when enabled.
// RULE_09 - bit 24 set on parity pin seen during write, when enabled.
// RULE_10 - bit 24 set on split completion reporting write parity error.
// RULE_11 - devsel timing bits 26:25 read 01, medium decode.
// RULE_12 - bit 27 set when bridge signals target abort as target.
// RULE_13 - bit 28 set when bridge as initiator sees target abort.
// RULE_14 - bit 29 set on master abort on secondary.
// RULE_15 - bit 30 set when system error pin seen asserted.
// RULE_16 - bit 31 set on any address or data parity error, always.
// RULE_17 - bridge control bit 16 enables parity reporting into bit 24.
// RULE_18 - sticky flags stay set until written one; zero leaves them.
// RULE_19 - reserved bits read zero; writes to them do nothing.
module bsc_regs
    import bsc_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic PCI_MODE,
    input wire logic RD_DATA_PERR,
    input wire logic WR_DATA_PHASE,
    input wire logic SECONDARY_PARITY_ERROR_PIN_N,
    input wire logic SPLIT_WR_PERR_MSG,
    input wire logic TGT_ABORT_SIGNALED,
    input wire logic TGT_ABORT_RECEIVED,
    input wire logic MASTER_ABORT_SEEN,
    input wire logic SYSTEM_ERROR_PIN_N,
    input wire logic ADDR_PERR,
    input wire logic DATA_PERR,
    output logic [7:0] SUB_BUS,
    output logic [7:0] SEC_LAT_TIMER,
    output logic [3:0] IO_BASE,
    output logic [3:0] IO_LIMIT,
    output logic PARITY_EN,
    output logic IRQ
);
    logic [7:0] sub_bus_q;
    logic [7:0] sec_lat_q;
    logic [3:0] io_base_q;
    logic [3:0] io_limit_q;
    logic par_en_q;
    logic [31:0] sticky_q;
    logic [31:0] sticky_d;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] mask_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_val;
    logic [31:0] word_bus;
    logic [31:0] word_io;
    logic wr_bus;
    logic wr_io;
    logic wr_ctl;
    logic wr_mask;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    assign wr_bus = WR && (ADDR == OFS_BUS_NUM);
    assign wr_io = WR && (ADDR == OFS_IO_STS);
    assign wr_ctl = WR && (ADDR == OFS_BRIDGE_CTL);
    assign wr_mask = WR && (ADDR == OFS_IRQ_MASK);

    // RULE_01 subordinate bus field
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            sub_bus_q <= SUB_BUS_RST;
        else if (wr_bus)
            sub_bus_q <= WDATA[SUB_BUS_LSB +: 8];
    end

    // RULE_02 latency timer field
    // reset value is zero whatever the mode; only pci mode defines it
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            sec_lat_q <= SEC_LAT_RST;
        else if (wr_bus)
            sec_lat_q <= WDATA[SEC_LAT_LSB +: 8];
    end

    // RULE_04 io base field
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            io_base_q <= IO_BASE_RST;
        else if (wr_io)
            io_base_q <= WDATA[IO_BASE_LSB +: 4];
    end

    // RULE_05 io limit field
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            io_limit_q <= IO_LIMIT_RST;
        else if (wr_io)
            io_limit_q <= WDATA[IO_LIMIT_LSB +: 4];
    end

    // RULE_17 parity enable bit
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            par_en_q <= 1'b0;
        else if (wr_ctl)
            par_en_q <= WDATA[PAR_EN_BIT];
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            mask_q <= IRQ_MASK_RST;
        else if (wr_mask)
            mask_q <= WDATA & STICKY_MASK;
    end

    // error event collection
    always_comb
    begin
        set_vec = 32'h0000_0000;
        // RULE_08 read parity error
        // RULE_09 parity pin during write
        // RULE_10 split completion report
        // RULE_17 gated by enable
        set_vec[MDPE_BIT] = par_en_q && (RD_DATA_PERR
            || (WR_DATA_PHASE && !SECONDARY_PARITY_ERROR_PIN_N)
            || SPLIT_WR_PERR_MSG);
        // RULE_12 signaled target abort
        set_vec[STA_BIT] = TGT_ABORT_SIGNALED;
        // RULE_13 received target abort
        set_vec[RTA_BIT] = TGT_ABORT_RECEIVED;
        // RULE_14 master abort seen
        set_vec[RMA_BIT] = MASTER_ABORT_SEEN;
        // RULE_15 system error pin
        set_vec[RSE_BIT] = !SYSTEM_ERROR_PIN_N;
        // RULE_16 ungated parity detect
        set_vec[DPE_BIT] = ADDR_PERR || DATA_PERR || RD_DATA_PERR;
    end

    assign clr_vec = wr_io ? (WDATA & STICKY_MASK) : 32'h0000_0000;

    // RULE_18 write one to clear
    // a new event in the clearing cycle wins, so no error is lost
    always_comb
    begin
        sticky_d = ((sticky_q & ~clr_vec) | set_vec) & STICKY_MASK;
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            sticky_q <= STICKY_RST;
        else
            sticky_q <= sticky_d;
    end

    // read composition
    always_comb
    begin
        word_bus = 32'h0000_0000;
        word_bus[SUB_BUS_LSB +: 8] = sub_bus_q;
        word_bus[SEC_LAT_LSB +: 8] = sec_lat_q;
    end

    always_comb
    begin
        // RULE_19 reserved bits zero
        word_io = sticky_q;
        // RULE_03 32 bit io codes
        word_io[IO_BASE_CAP_LSB +: 2] = IO_CAP_32BIT;
        word_io[IO_LIMIT_CAP_LSB +: 2] = IO_CAP_32BIT;
        word_io[IO_BASE_LSB +: 4] = io_base_q;
        word_io[IO_LIMIT_LSB +: 4] = io_limit_q;
        // RULE_06 66MHz capable
        word_io[CAP_66MHZ_BIT] = 1'b1;
        // RULE_07 fast back to back
        word_io[FAST_B2B_BIT] = PCI_MODE;
        // RULE_11 medium devsel timing
        word_io[DEVSEL_LSB +: 2] = DEVSEL_MEDIUM;
    end

    // unmapped addresses read zero
    always_comb
    begin
        case (ADDR)
            OFS_BUS_NUM: rd_val = word_bus;
            OFS_IO_STS: rd_val = word_io;
            OFS_BRIDGE_CTL: rd_val = {15'h0000, par_en_q, 16'h0000};
            OFS_IRQ_MASK: rd_val = mask_q;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            rdata_q <= 32'h0000_0000;
        else if (RD)
            rdata_q <= rd_val;
        else
            rdata_q <= 32'h0000_0000;
    end

    assign RDATA = rdata_q;
    assign SUB_BUS = sub_bus_q;
    assign SEC_LAT_TIMER = sec_lat_q;
    assign IO_BASE = io_base_q;
    assign IO_LIMIT = io_limit_q;
    assign PARITY_EN = par_en_q;
    assign IRQ = |(sticky_q & mask_q);

    property p_sub_bus;
        wr_bus |=> (SUB_BUS == $past(WDATA[23:16]));
    endproperty
    a_sub_bus: // RULE_01
        assert property (p_sub_bus) else $error("subordinate bus lost");

    property p_lat;
        wr_bus ##1 !wr_bus |-> ##1 (SEC_LAT_TIMER == $past(WDATA[31:24], 2));
    endproperty
    a_lat: // RULE_02
        assert property (p_lat) else $error("latency timer wrong");

    property p_io_cap;
        RD && ADDR == OFS_IO_STS |=> RDATA[1:0] == 2'h1 && RDATA[9:8] == 2'h1;
    endproperty
    a_io_cap: // RULE_03
        assert property (p_io_cap) else $error("io capability code wrong");

    property p_io_win;
        wr_io |=> IO_BASE == $past(WDATA[7:4])
            && IO_LIMIT == $past(WDATA[15:12]);
    endproperty
    a_io_win: // RULE_04 RULE_05
        assert property (p_io_win) else $error("io window not written");

    property p_caps;
        RD && ADDR == OFS_IO_STS |=> RDATA[21] && RDATA[26:25] == 2'h1
            && RDATA[23] == $past(PCI_MODE);
    endproperty
    a_caps: // RULE_06 RULE_07 RULE_11
        assert property (p_caps) else $error("fixed status bits wrong");

    property p_mdpe;
        PARITY_EN && (RD_DATA_PERR || SPLIT_WR_PERR_MSG
            || (WR_DATA_PHASE && !SECONDARY_PARITY_ERROR_PIN_N))
            |=> ##1 (IRQ || !mask_q[24]) && sticky_q[24];
    endproperty
    a_mdpe: // RULE_08 RULE_09 RULE_10
        assert property (p_mdpe) else $error("parity flag not set");

    property p_par_off;
        !PARITY_EN && !(wr_io && WDATA[24]) |=> $stable(sticky_q[24]);
    endproperty
    a_par_off: // RULE_17
        assert property (p_par_off) else $error("bit 24 moved while off");

    property p_aborts;
        TGT_ABORT_SIGNALED || TGT_ABORT_RECEIVED || MASTER_ABORT_SEEN
            || !SYSTEM_ERROR_PIN_N
            |=> (sticky_q[27] || !$past(TGT_ABORT_SIGNALED))
            && (sticky_q[28] || !$past(TGT_ABORT_RECEIVED))
            && (sticky_q[29] || !$past(MASTER_ABORT_SEEN))
            && (sticky_q[30] || $past(SYSTEM_ERROR_PIN_N));
    endproperty
    a_aborts: // RULE_12 RULE_13 RULE_14 RULE_15
        assert property (p_aborts) else $error("abort flag not set");

    property p_dpe;
        ADDR_PERR || DATA_PERR || RD_DATA_PERR |=> sticky_q[31];
    endproperty
    a_dpe: // RULE_16
        assert property (p_dpe) else $error("detected parity not set");

    property p_sticky;
        sticky_q[29] && !(wr_io && WDATA[29]) |=> sticky_q[29];
    endproperty
    a_sticky: // RULE_18
        assert property (p_sticky) else $error("sticky flag dropped");

    property p_resv;
        RD && ADDR == OFS_IO_STS |=> RDATA[3:2] == 2'h0
            && RDATA[11:10] == 2'h0 && RDATA[20:16] == 5'h00 && !RDATA[22];
    endproperty
    a_resv: // RULE_19
        assert property (p_resv) else $error("reserved bits not zero");

    property p_bus_rd;
        RD && ADDR == OFS_BUS_NUM |=> RDATA[15:0] == 16'h0000
            && RDATA[23:16] == $past(SUB_BUS)
            && RDATA[31:24] == $past(SEC_LAT_TIMER);
    endproperty
    a_bus_rd: // RULE_01 RULE_02
        assert property (p_bus_rd) else $error("bus number word wrong");

    property p_io_rd;
        RD && ADDR == OFS_IO_STS |=> RDATA[7:4] == $past(IO_BASE)
            && RDATA[15:12] == $past(IO_LIMIT);
    endproperty
    a_io_rd: // RULE_04 RULE_05
        assert property (p_io_rd) else $error("io window read wrong");

    property p_bus_hold;
        !wr_bus |=> $stable(SUB_BUS) && $stable(SEC_LAT_TIMER);
    endproperty
    a_bus_hold: // RULE_01 RULE_02
        assert property (p_bus_hold) else $error("bus number word moved");

    property p_io_hold;
        !wr_io |=> $stable(IO_BASE) && $stable(IO_LIMIT);
    endproperty
    a_io_hold: // RULE_04 RULE_05
        assert property (p_io_hold) else $error("io window moved");

    property p_par_wr;
        wr_ctl |=> PARITY_EN == $past(WDATA[16]);
    endproperty
    a_par_wr: // RULE_17
        assert property (p_par_wr) else $error("parity enable not written");

    property p_ctl_rd;
        RD && ADDR == OFS_BRIDGE_CTL |=> RDATA[16] == $past(PARITY_EN)
            && RDATA[15:0] == 16'h0000 && RDATA[31:17] == 15'h0000;
    endproperty
    a_ctl_rd: // RULE_17
        assert property (p_ctl_rd) else $error("bridge control read wrong");

    property p_clear;
        wr_io && WDATA[29] && !MASTER_ABORT_SEEN |=> !sticky_q[29];
    endproperty
    a_clear: // RULE_18
        assert property (p_clear) else $error("flag not cleared by one");

    property p_keep_24;
        sticky_q[24] && !(wr_io && WDATA[24]) |=> sticky_q[24];
    endproperty
    a_keep_24: // RULE_18
        assert property (p_keep_24) else $error("parity flag dropped");

    property p_dpe_clear;
        wr_io && WDATA[31] && !ADDR_PERR && !DATA_PERR && !RD_DATA_PERR
            |=> !sticky_q[31];
    endproperty
    a_dpe_clear: // RULE_16 RULE_18
        assert property (p_dpe_clear) else $error("detected parity stuck");

    property p_mdpe_quiet;
        !sticky_q[24] && !RD_DATA_PERR && !SPLIT_WR_PERR_MSG
            && !(WR_DATA_PHASE && !SECONDARY_PARITY_ERROR_PIN_N)
            |=> !sticky_q[24];
    endproperty
    a_mdpe_quiet: // RULE_09
        assert property (p_mdpe_quiet) else $error("bit 24 set spuriously");

    property p_unmapped;
        RD && ADDR != OFS_BUS_NUM && ADDR != OFS_IO_STS
            && ADDR != OFS_BRIDGE_CTL && ADDR != OFS_IRQ_MASK
            |=> RDATA == 32'h0000_0000;
    endproperty
    a_unmapped: // RULE_19
        assert property (p_unmapped) else $error("unmapped read not zero");

    property p_rd_idle;
        !RD |=> RDATA == 32'h0000_0000;
    endproperty
    a_rd_idle: // RULE_19
        assert property (p_rd_idle) else $error("read data not idle");
endmodule

// [verification/bsc_regs_tb_top.sv]
`timescale 1ns/1ps
module bsc_regs_tb_top
    import bsc_pkg::*;
();
    logic CLK = 0, NRST = 0, WR = 0, RD = 0, PCI_MODE = 0;
    logic [7:0] ADDR = 8'h00, SUB_BUS, SEC_LAT_TIMER, sub, lat;
    logic [31:0] WDATA = 32'h0, RDATA, st, mk;
    logic [3:0] EV = 4'h0, IO_BASE, IO_LIMIT, iob, iol;
    logic [9:0] ln;
    logic [7:0] am [5] = '{8'h18, 8'h1c, 8'h3c, 8'h40, 8'h44};
    logic PARITY_EN, IRQ, pe;
    int mismatches = 0, total_checks = 0;
    always #2.5 CLK = ~CLK;
    bsc_sec_agent agent (.CLK(CLK), .NRST(NRST), .EV(EV), .LINES(ln));
    bsc_regs uut (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .PCI_MODE(PCI_MODE),
        .RD_DATA_PERR(ln[0]), .SECONDARY_PARITY_ERROR_PIN_N(ln[1]),
        .WR_DATA_PHASE(ln[2]), .SPLIT_WR_PERR_MSG(ln[3]),
        .TGT_ABORT_SIGNALED(ln[4]), .TGT_ABORT_RECEIVED(ln[5]),
        .MASTER_ABORT_SEEN(ln[6]), .SYSTEM_ERROR_PIN_N(ln[7]),
        .ADDR_PERR(ln[8]), .DATA_PERR(ln[9]), .SUB_BUS(SUB_BUS),
        .SEC_LAT_TIMER(SEC_LAT_TIMER), .IO_BASE(IO_BASE),
        .IO_LIMIT(IO_LIMIT), .PARITY_EN(PARITY_EN), .IRQ(IRQ));
    task automatic chk(logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("Error %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic [31:0] exp_rd(logic [7:0] a);
        case (a)
            OFS_BUS_NUM: return {lat, sub, 16'h0000};
            OFS_IO_STS: return st | 32'h0220_0101 |
                {8'h00, PCI_MODE, 7'h00, iol, 4'h0, iob, 4'h0};
            OFS_BRIDGE_CTL: return {15'h0, pe, 16'h0};
            OFS_IRQ_MASK: return mk;
            default: return 32'h0;
        endcase
    endfunction
    task automatic outs;
        chk({SEC_LAT_TIMER, SUB_BUS, 8'h0, IO_LIMIT, IO_BASE},
            {lat, sub, 8'h0, iol, iob});
        chk({31'h0, PARITY_EN}, {31'h0, pe});
        chk({31'h0, IRQ}, {31'h0, |(st & mk)});
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge CLK);
        RD <= 1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 0;
        #1 chk(RDATA, exp_rd(a));
        @(posedge CLK);
        #1 chk(RDATA, 32'h0);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge CLK);
        WR <= 1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 0;
        case (a)
            OFS_BUS_NUM: {lat, sub} = d[31:16];
            OFS_IO_STS:
            begin
                {iol, iob} = {d[15:12], d[7:4]};
                st &= ~(d & 32'hf900_0000);
            end
            OFS_BRIDGE_CTL: pe = d[16];
            OFS_IRQ_MASK: mk = d & 32'hf900_0000;
            default: ;
        endcase
        #1 outs();
    endtask
    task automatic ev(int c);
        @(posedge CLK);
        EV <= 4'(c);
        @(posedge CLK);
        EV <= 4'h0;
        @(posedge CLK);
        if (pe && c >= 1 && c <= 3)
            st[24] = 1;
        if (c == 1 || c == 8 || c == 9)
            st[31] = 1;
        if (c >= 4 && c <= 7)
            st[c+23] = 1;
        #1 outs();
    endtask
    task automatic rst;
        NRST <= 0;
        repeat (20) @(posedge CLK);
        NRST <= 1;
        {st, mk, sub, lat, iob, iol, pe} = '0;
        #1 outs();
    endtask
    initial
    begin
        #50000 mismatches++;
        summarize();
    end
    initial
    begin
        void'($urandom(19472));
        rst();
        for (int i = 0; i < 5; i++)
        begin
            rd(am[i]);
            wr(am[i], 32'hffff_ffff);
            rd(am[i]);
        end
        @(posedge CLK) PCI_MODE <= 1;
        for (int c = 1; c <= 10; c++)
            ev(c);
        wr(OFS_IO_STS, 32'h0);
        rd(OFS_IO_STS);
        wr(OFS_BRIDGE_CTL, 32'h0);
        wr(OFS_IO_STS, 32'hffff_ffff);
        for (int c = 1; c <= 3; c++)
            ev(c);
        rd(OFS_IO_STS);
        wr(OFS_IRQ_MASK, 32'h0100_0000);
        wr(OFS_IRQ_MASK, 32'h8000_0000);
        for (int i = 0; i < 60; i++)
        begin
            logic [7:0] ra;
            ra = $urandom_range(0, 1) ? am[$urandom_range(0, 3)]
                : 8'($urandom);
            case ($urandom_range(0, 2))
                0: wr(ra, $urandom);
                1: rd(ra);
                default: ev($urandom_range(0, 10));
            endcase
            @(posedge CLK) PCI_MODE <= 1'($urandom);
        end
        rst();
        rd(OFS_IO_STS);
        summarize();
    end
endmodule

// [verification/bsc_sec_agent.sv]
`timescale 1ns/1ps
// secondary bus agent: one cycle of event lines per code on EV
// active-low pins are pulled up, so released pins sit high
module bsc_sec_agent
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [3:0] EV,
    output logic [9:0] LINES
);
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            LINES <= 10'h082;
        else
            case (EV)
                4'h1: LINES <= 10'h083;
                4'h2: LINES <= 10'h084;
                4'h3: LINES <= 10'h08a;
                4'h4: LINES <= 10'h092;
                4'h5: LINES <= 10'h0a2;
                4'h6: LINES <= 10'h0c2;
                4'h7: LINES <= 10'h002;
                4'h8: LINES <= 10'h182;
                4'h9: LINES <= 10'h282;
                4'ha: LINES <= 10'h086;
                default: LINES <= 10'h082;
            endcase
    end
endmodule
